// [fpdcm_consts.svh]
// Offsets, field positions, reset values and codes of the execution unit
`ifndef FPDCM_CONSTS_SVH
`define FPDCM_CONSTS_SVH

// Register port word addresses; accumulator n high word at 2n, low at 2n+1
`define FPDCM_ADDR_ACC_LAST 4'h7
`define FPDCM_ADDR_STATUS   4'h8
`define FPDCM_ADDR_ERRCODE  4'h9

// Program status bit positions
`define FPDCM_ST_CARRY      0
`define FPDCM_ST_OVF        1
`define FPDCM_ST_ZERO       2
`define FPDCM_ST_NEG        3
`define FPDCM_ST_CHOP       5
`define FPDCM_ST_DBL        7
`define FPDCM_ST_OVF_TE     9
`define FPDCM_ST_UNF_TE     10
`define FPDCM_ST_UNDEF_TE   11
`define FPDCM_ST_VARIANT_C  12
`define FPDCM_ST_MASK       32'h0000_1eaf
`define FPDCM_ST_RESET      32'h0000_1000

// Error codes
`define FPDCM_ERR_NONE      4'h0
`define FPDCM_ERR_DIV_ZERO  4'h4
`define FPDCM_ERR_OVF       4'h8
`define FPDCM_ERR_UNF       4'ha
`define FPDCM_ERR_UNDEF     4'hc

// Opcode high byte
`define FPDCM_OPC_DIV       8'hf9
`define FPDCM_OPC_CMP       8'hf7
`define FPDCM_OPC_MOD       8'hf3

// Exponent bias (200 octal) and significance limits
`define FPDCM_BIAS          11'h080
`define FPDCM_LIM_SINGLE    11'h018
`define FPDCM_LIM_DOUBLE    11'h038

// Iteration counts of the sequential datapaths
`define FPDCM_DIV_STEPS     6'h3b
`define FPDCM_MUL_STEPS     6'h38

`endif

// [fpdcm_pkg.sv]
// Types shared by the floating divide, compare and modulo unit
`default_nettype none
package fpdcm_pkg;

	typedef enum logic [1:0]
	{
		st_idle    = 2'b00,
		st_div_run = 2'b01,
		st_mul_run = 2'b10
	} fpdcm_state_t;

	typedef enum logic [1:0]
	{
		op_none = 2'b00,
		op_div  = 2'b01,
		op_cmp  = 2'b10,
		op_mod  = 2'b11
	} fpdcm_op_t;

endpackage : fpdcm_pkg
`default_nettype wire

// [fpdcm_divider.sv]
// Restoring mantissa divider, one quotient bit per clock
`timescale 1ns/10ps
`default_nettype none
`include "fpdcm_consts.svh"
module fpdcm_divider
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// Operands
	input  wire logic        start,
	input  wire logic [55:0] dividend,
	input  wire logic [55:0] divisor,
	// Result
	output logic      [58:0] quotient,
	output logic             done
);
	logic [56:0] rem;
	logic [55:0] dvs;
	logic [5:0]  count;
	logic        run;
	logic [56:0] diff;

	assign diff = rem - {1'b0, dvs};

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			rem      <= 57'h0;
			dvs      <= 56'h0;
			count    <= 6'h0;
			run      <= 1'b0;
			quotient <= 59'h0;
			done     <= 1'b0;
		end
		else if (start)
		begin
			rem      <= {1'b0, dividend};
			dvs      <= divisor;
			count    <= `FPDCM_DIV_STEPS;
			run      <= 1'b1;
			done     <= 1'b0;
		end
		else if (run)
		begin
			// First bit carries weight one: quotient lies in (1/2, 2)
			if (rem >= {1'b0, dvs})
			begin
				rem      <= {diff[55:0], 1'b0};
				quotient <= {quotient[57:0], 1'b1};
			end
			else
			begin
				rem      <= {rem[55:0], 1'b0};
				quotient <= {quotient[57:0], 1'b0};
			end
			count <= count - 6'h1;
			run   <= (count != 6'h1);
			done  <= (count == 6'h1);
		end
		else
			done <= 1'b0;
	end

endmodule : fpdcm_divider
`default_nettype wire

// [fpdcm_multiplier.sv]
// Shift-and-add mantissa multiplier, one multiplier bit per clock
`timescale 1ns/10ps
`default_nettype none
`include "fpdcm_consts.svh"
module fpdcm_multiplier
(
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         rst,
	// Operands
	input  wire logic         start,
	input  wire logic [55:0]  mcand,
	input  wire logic [55:0]  mplier,
	// Result
	output logic      [111:0] product,
	output logic              done
);
	logic [55:0] mc;
	logic [5:0]  count;
	logic        run;
	logic [56:0] sum;

	assign sum = {1'b0, product[111:56]} + (product[0] ? {1'b0, mc} : 57'h0);

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			mc      <= 56'h0;
			count   <= 6'h0;
			run     <= 1'b0;
			product <= 112'h0;
			done    <= 1'b0;
		end
		else if (start)
		begin
			mc      <= mcand;
			product <= {56'h0, mplier};
			count   <= `FPDCM_MUL_STEPS;
			run     <= 1'b1;
			done    <= 1'b0;
		end
		else if (run)
		begin
			product <= {sum, product[55:1]};
			count   <= count - 6'h1;
			run     <= (count != 6'h1);
			done    <= (count == 6'h1);
		end
		else
			done <= 1'b0;
	end

endmodule : fpdcm_multiplier
`default_nettype wire

// [fpdcm_unit.sv]
// Floating divide, compare and multiply-integerize execution unit
`timescale 1ns/10ps
`default_nettype none
`include "fpdcm_consts.svh"
// Overview of operation
// - Zero biased exponent means exact zero.
// - Zero divisor aborts, keeps destination, code 4.
// - Zero divisor aborts with a trap.
// - Quotient rounded or chopped per status bits.
// - Untrapped overflow (variant C), underflow store zero.
// - Trapped overflow or underflow keeps faulty result.
// - Trapped exponent off by 400 octal.
// - Error within one or half LSB.
// - Minus zero only when trapped or variant B.
// - Minus zero source traps before execution.
// - Compare sets zero, negative; clears carry, overflow.
// - Compare modifies only the condition flags.
// - Integerize decoded from opcode 171 octal.
// - Product split into signed integer and fraction.
// - Biased exponent is true exponent plus 200.
// - Even accumulator: integer goes to next one.
// - Odd accumulator: integer part discarded.
// - Significance limit 24 or 56 bits.
// - Trapped product overflow: chopped integer, zero fraction.
// - Untrapped overflow: B as trapped, C zeros.
// - Huge product: chopped integer, zero fraction.
// - Trapped underflow: zero integer, offset fraction.
// - Untrapped underflow: both parts exact zero.
// - Integerize flags from fractional result.
module fpdcm_unit
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Instruction issue
	input  wire logic        instr_valid,
	input  wire logic [15:0] instr_word,
	input  wire logic [63:0] float_source_operand,
	output logic             busy,
	// Completion and status
	output logic             instr_done,
	output logic             instr_trap,
	output logic      [3:0]  float_error_code,
	output logic             float_carry_flag,
	output logic             float_overflow_flag,
	output logic             float_zero_flag,
	output logic             float_negative_flag
);
	fpdcm_pkg::fpdcm_state_t state;
	fpdcm_pkg::fpdcm_op_t    op_kind;
	logic [63:0] acc [0:3];
	logic [31:0] float_program_status;
	logic [1:0]  op_acc;
	logic        op_sign;
	logic [7:0]  op_ea;
	logic [7:0]  op_eb;

	logic        dbl;
	logic        chop;
	logic        ovf_te;
	logic        unf_te;
	logic        varc;
	logic [1:0]  accumulator_select;
	logic [63:0] src_v;
	logic [63:0] acc_v;
	logic        src_zero;
	logic        acc_zero;
	logic        issue;
	logic        div_start;
	logic        mul_start;
	logic [58:0] quotient_value;
	logic        div_done;
	logic [111:0] product_value;
	logic        mul_done;

	// Completion results
	logic        fin;
	logic        wr_a;
	logic [1:0]  idx_a;
	logic [63:0] val_a;
	logic        wr_b;
	logic [1:0]  idx_b;
	logic [63:0] val_b;
	logic        set_flags;
	logic [3:0]  next_flags;
	logic        do_trap;
	logic [3:0]  next_code;

	function automatic logic [63:0] prec_mask(input logic [63:0] v,
		input logic d);
		return d ? v : {v[63:32], 32'h0};
	endfunction : prec_mask

	function automatic logic [56:0] round_mant(input logic [58:0] v,
		input logic d, input logic c);
		logic [56:0] t;
		logic [24:0] s;
		t = {1'b0, v[58:3]} + {56'h0, v[2] & ~c};
		s = {1'b0, v[58:35]} + {24'h0, v[34] & ~c};
		if (!d)
			t = {s, 32'h0};
		// Carry out renormalises to one half with exponent plus one
		if (t[56])
			t = {2'b11, 55'h0};
		return t;
	endfunction : round_mant

	function automatic logic [5:0] lead_zeros(input logic [58:0] v);
		logic [5:0] n;
		logic       found;
		n = 6'h3b;
		found = 1'b0;
		for (int i = 58; i >= 0; i--)
		begin
			if (!found && v[i])
			begin
				n = 6'(58 - i);
				found = 1'b1;
			end
		end
		return n;
	endfunction : lead_zeros

	assign dbl    = float_program_status[`FPDCM_ST_DBL];
	assign chop   = float_program_status[`FPDCM_ST_CHOP];
	assign ovf_te = float_program_status[`FPDCM_ST_OVF_TE];
	assign unf_te = float_program_status[`FPDCM_ST_UNF_TE];
	assign varc   = float_program_status[`FPDCM_ST_VARIANT_C];

	assign float_carry_flag    = float_program_status[`FPDCM_ST_CARRY];
	assign float_overflow_flag = float_program_status[`FPDCM_ST_OVF];
	assign float_zero_flag     = float_program_status[`FPDCM_ST_ZERO];
	assign float_negative_flag = float_program_status[`FPDCM_ST_NEG];

	assign accumulator_select = instr_word[7:6];
	assign src_v    = prec_mask(float_source_operand, dbl);
	assign acc_v    = prec_mask(acc[accumulator_select], dbl);
	assign src_zero = (src_v[62:55] == 8'h0);
	assign acc_zero = (acc_v[62:55] == 8'h0);

	always_comb
	begin
		unique case (instr_word[15:8])
			`FPDCM_OPC_DIV: op_kind = fpdcm_pkg::op_div;
			`FPDCM_OPC_CMP: op_kind = fpdcm_pkg::op_cmp;
			`FPDCM_OPC_MOD: op_kind = fpdcm_pkg::op_mod;
			default:        op_kind = fpdcm_pkg::op_none;
		endcase
	end

	assign issue = instr_valid && (state == fpdcm_pkg::st_idle) &&
		(op_kind != fpdcm_pkg::op_none);
	assign div_start = issue && (op_kind == fpdcm_pkg::op_div) &&
		!(float_program_status[`FPDCM_ST_UNDEF_TE] && src_v[63] &&
		src_zero) && !src_zero && !acc_zero;
	assign mul_start = issue && (op_kind == fpdcm_pkg::op_mod) &&
		!(float_program_status[`FPDCM_ST_UNDEF_TE] && src_v[63] &&
		src_zero) && !src_zero && !acc_zero;

	fpdcm_divider fpdcm_divider_inst
	(
		.mclk     (mclk),
		.rst      (rst),
		.start    (div_start),
		.dividend ({1'b1, acc_v[54:0]}),
		.divisor  ({1'b1, src_v[54:0]}),
		.quotient (quotient_value),
		.done     (div_done)
	);

	fpdcm_multiplier fpdcm_multiplier_inst
	(
		.mclk    (mclk),
		.rst     (rst),
		.start   (mul_start),
		.mcand   ({1'b1, acc_v[54:0]}),
		.mplier  ({1'b1, src_v[54:0]}),
		.product (product_value),
		.done    (mul_done)
	);

	// Divide datapath tail
	logic [58:0] dv;
	logic [10:0] de;
	logic [56:0] drnd;
	logic [10:0] dre;
	logic        dovf;
	logic        dunf;
	logic [63:0] dpack;

	assign dv   = quotient_value[58] ? quotient_value :
		{quotient_value[57:0], 1'b0};
	assign de   = {3'h0, op_ea} - {3'h0, op_eb} + `FPDCM_BIAS +
		{10'h0, quotient_value[58]};
	assign drnd = round_mant(dv, dbl, chop);
	assign dre  = de + {10'h0, drnd[56]};
	assign dovf = !dre[10] && (dre[9:8] != 2'h0);
	assign dunf = dre[10] || (dre[9:0] == 10'h0);
	// Low eight bits give the 400 octal offset on a trapped result
	assign dpack = {op_sign, dre[7:0], drnd[54:0]};

	// Multiply-integerize datapath tail
	logic [58:0] mv;
	logic [10:0] me;
	logic [10:0] mk;
	logic [10:0] lim;
	logic        movf;
	logic        munf;
	logic        mbig;
	logic        mint;
	logic [5:0]  kk;
	logic [58:0] imant;
	logic [58:0] fbits;
	logic [5:0]  lz;
	logic [58:0] fn;
	logic [10:0] fe;
	logic [56:0] frnd;
	logic [10:0] fre;
	logic [63:0] int_chop;
	logic [63:0] int_part;
	logic [63:0] frac_part;

	assign mv   = product_value[111] ? product_value[111:53] :
		product_value[110:52];
	assign me   = {3'h0, op_ea} + {3'h0, op_eb} - `FPDCM_BIAS -
		{10'h0, ~product_value[111]};
	assign mk   = me - `FPDCM_BIAS;
	assign lim  = dbl ? `FPDCM_LIM_DOUBLE : `FPDCM_LIM_SINGLE;
	assign movf = !me[10] && (me[9:8] != 2'h0);
	assign munf = me[10] || (me[9:0] == 10'h0);
	assign mbig = !mk[10] && (mk >= lim);
	assign mint = !mk[10] && (mk != 11'h0);
	assign kk   = mint ? mk[5:0] : 6'h0;
	// Integer part keeps the top K bits; the rest is the fraction
	assign imant = mv & ~({59{1'b1}} >> kk);
	assign fbits = mv << kk;
	assign lz    = lead_zeros(fbits);
	assign fn    = fbits << lz;
	assign fe    = (mint ? `FPDCM_BIAS : me) - {5'h0, lz};
	assign frnd  = round_mant(fn, dbl, chop);
	assign fre   = fe + {10'h0, frnd[56]};
	assign int_chop  = {op_sign, me[7:0],
		dbl ? mv[57:3] : {mv[57:35], 32'h0}};
	assign int_part  = {op_sign, me[7:0], imant[57:3]};
	assign frac_part = (fbits == 59'h0) ? 64'h0 :
		{op_sign, fre[7:0], frnd[54:0]};

	// Compare on sign and magnitude, zero exponent counting as zero
	logic [62:0] smag;
	logic [62:0] amag;
	logic        ssgn;
	logic        asgn;
	logic        cmp_eq;
	logic        cmp_lt;

	assign smag   = src_zero ? 63'h0 : src_v[62:0];
	assign amag   = acc_zero ? 63'h0 : acc_v[62:0];
	assign ssgn   = src_zero ? 1'b0 : src_v[63];
	assign asgn   = acc_zero ? 1'b0 : acc_v[63];
	assign cmp_eq = (ssgn == asgn) && (smag == amag);
	assign cmp_lt = (ssgn != asgn) ? ssgn :
		(ssgn ? (smag > amag) : (smag < amag));

	always_comb
	begin
		fin        = 1'b0;
		wr_a       = 1'b0;
		idx_a      = op_acc;
		val_a      = 64'h0;
		wr_b       = 1'b0;
		idx_b      = {op_acc[1], 1'b1};
		val_b      = 64'h0;
		set_flags  = 1'b0;
		next_flags = 4'h0;
		do_trap    = 1'b0;
		next_code  = `FPDCM_ERR_NONE;
		if (issue)
		begin
			fin   = !(div_start || mul_start);
			idx_a = accumulator_select;
			idx_b = {accumulator_select[1], 1'b1};
			if (float_program_status[`FPDCM_ST_UNDEF_TE] && src_v[63] &&
				src_zero)
			begin
				do_trap   = 1'b1;
				next_code = `FPDCM_ERR_UNDEF;
			end
			else if (op_kind == fpdcm_pkg::op_cmp)
			begin
				set_flags = 1'b1;
				next_flags[`FPDCM_ST_ZERO] = cmp_eq;
				next_flags[`FPDCM_ST_NEG]  = cmp_lt;
			end
			else if (op_kind == fpdcm_pkg::op_div && src_zero)
			begin
				do_trap   = 1'b1;
				next_code = `FPDCM_ERR_DIV_ZERO;
			end
			else if (acc_zero || (op_kind == fpdcm_pkg::op_mod && src_zero))
			begin
				wr_a = 1'b1;
				wr_b = (op_kind == fpdcm_pkg::op_mod) &&
					!accumulator_select[0];
				set_flags = 1'b1;
				next_flags[`FPDCM_ST_ZERO] = 1'b1;
			end
		end
		else if (state == fpdcm_pkg::st_div_run && div_done)
		begin
			fin       = 1'b1;
			wr_a      = 1'b1;
			set_flags = 1'b1;
			if (dovf)
			begin
				do_trap   = ovf_te;
				next_code = `FPDCM_ERR_OVF;
				val_a     = (ovf_te || !varc) ? dpack : 64'h0;
			end
			else if (dunf)
			begin
				do_trap   = unf_te;
				next_code = `FPDCM_ERR_UNF;
				val_a     = unf_te ? dpack : 64'h0;
			end
			else
				val_a = dpack;
			next_flags[`FPDCM_ST_OVF]  = dovf;
			next_flags[`FPDCM_ST_ZERO] = (val_a[62:55] == 8'h0);
			// Minus zero is a zero, never a negative value
			next_flags[`FPDCM_ST_NEG]  = val_a[63] && (val_a[62:55] != 8'h0);
		end
		else if (state == fpdcm_pkg::st_mul_run && mul_done)
		begin
			fin       = 1'b1;
			wr_a      = 1'b1;
			wr_b      = !op_acc[0];
			set_flags = 1'b1;
			if (movf)
			begin
				do_trap   = ovf_te;
				next_code = `FPDCM_ERR_OVF;
				val_b     = (ovf_te || !varc) ? int_chop : 64'h0;
			end
			else if (munf)
			begin
				do_trap   = unf_te;
				next_code = `FPDCM_ERR_UNF;
				val_a     = unf_te ? frac_part : 64'h0;
			end
			else if (mbig)
				val_b = int_chop;
			else if (mint)
			begin
				val_b = int_part;
				val_a = frac_part;
			end
			else
				val_a = frac_part;
			next_flags[`FPDCM_ST_OVF]  = movf && varc;
			next_flags[`FPDCM_ST_ZERO] = (val_a[62:55] == 8'h0);
			next_flags[`FPDCM_ST_NEG]  = val_a[63] &&
				(val_a[62:55] != 8'h0);
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			state <= fpdcm_pkg::st_idle;
		else
		begin
			unique case (state)
				fpdcm_pkg::st_idle:
					if (div_start)
						state <= fpdcm_pkg::st_div_run;
					else if (mul_start)
						state <= fpdcm_pkg::st_mul_run;
				fpdcm_pkg::st_div_run:
					if (div_done)
						state <= fpdcm_pkg::st_idle;
				fpdcm_pkg::st_mul_run:
					if (mul_done)
						state <= fpdcm_pkg::st_idle;
				default:
					state <= fpdcm_pkg::st_idle;
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			op_acc  <= 2'h0;
			op_sign <= 1'b0;
			op_ea   <= 8'h0;
			op_eb   <= 8'h0;
		end
		else if (issue)
		begin
			op_acc  <= accumulator_select;
			op_sign <= acc_v[63] ^ src_v[63];
			op_ea   <= acc_v[62:55];
			op_eb   <= src_v[62:55];
		end
	end

	// Accumulators; instruction results win over a software write
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			for (int i = 0; i < 4; i++)
				acc[i] <= 64'h0;
		end
		else
		begin
			if (reg_wr && reg_addr <= `FPDCM_ADDR_ACC_LAST)
			begin
				if (reg_addr[0])
					acc[reg_addr[2:1]][31:0] <= reg_wdata;
				else
					acc[reg_addr[2:1]][63:32] <= reg_wdata;
			end
			if (wr_b)
				acc[idx_b] <= val_b;
			if (wr_a)
				acc[idx_a] <= val_a;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			float_program_status <= `FPDCM_ST_RESET;
		else if (set_flags)
			float_program_status[3:0] <= next_flags;
		else if (reg_wr && reg_addr == `FPDCM_ADDR_STATUS)
			float_program_status <= reg_wdata & `FPDCM_ST_MASK;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			float_error_code <= `FPDCM_ERR_NONE;
		else if (do_trap)
			float_error_code <= next_code;
		else if (reg_wr && reg_addr == `FPDCM_ADDR_ERRCODE)
			float_error_code <= reg_wdata[3:0];
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			instr_done <= 1'b0;
			instr_trap <= 1'b0;
			busy       <= 1'b0;
		end
		else
		begin
			instr_done <= fin;
			instr_trap <= do_trap;
			busy       <= div_start || mul_start ||
				((state != fpdcm_pkg::st_idle) && !fin);
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			reg_rdata <= 32'h0;
		else if (!reg_rd)
			reg_rdata <= 32'h0;
		else if (reg_addr <= `FPDCM_ADDR_ACC_LAST)
			reg_rdata <= reg_addr[0] ? acc[reg_addr[2:1]][31:0] :
				acc[reg_addr[2:1]][63:32];
		else if (reg_addr == `FPDCM_ADDR_STATUS)
			reg_rdata <= float_program_status;
		else if (reg_addr == `FPDCM_ADDR_ERRCODE)
			reg_rdata <= {28'h0, float_error_code};
		else
			reg_rdata <= 32'h0;
	end

endmodule : fpdcm_unit
`default_nettype wire

// [fpdcm_unit_properties.sv]
// Port-level checks of the floating divide, compare and integerize unit
`timescale 1ns/10ps
`default_nettype none
module fpdcm_unit_properties
(
	// Clock and reset
	input wire logic        mclk,
	input wire logic        rst,
	// Instruction issue
	input wire logic        instr_valid,
	input wire logic [15:0] instr_word,
	input wire logic [63:0] float_source_operand,
	input wire logic        busy,
	// Completion and status
	input wire logic        instr_done,
	input wire logic        instr_trap,
	input wire logic [3:0]  float_error_code,
	input wire logic        float_carry_flag,
	input wire logic        float_overflow_flag,
	input wire logic        float_zero_flag,
	input wire logic        float_negative_flag
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic       take;
	logic [7:0] issued_op;
	assign take = instr_valid && !busy;
	// Latched opcode lets latency checks tell divide from integerize
	always_ff @(posedge mclk)
	begin
		if (rst)
			issued_op <= 8'h00;
		else if (take)
			issued_op <= instr_word[15:8];
	end
	AST_TRAP_DONE: assert property (instr_trap |-> instr_done)
		else $error("trap pulse without completion");
	AST_DIV_ZERO: assert property (take && instr_word[15:8] == 8'hf9
		&& float_source_operand[63:55] == 9'h000
		|=> instr_trap && float_error_code == 4'h4)
		else $error("zero divisor not aborted with code 4");
	AST_DIV_LAT: assert property ($rose(busy) && issued_op == 8'hf9
		|-> ##60 instr_done)
		else $error("divide did not finish on time");
	AST_MOD_LAT: assert property ($rose(busy) && issued_op == 8'hf3
		|-> ##57 instr_done)
		else $error("integerize did not finish on time");
	AST_BUSY_HOLD: assert property (busy |=> busy || instr_done)
		else $error("busy dropped without completion");
	AST_CMP_FLAGS: assert property (take && instr_word[15:8] == 8'hf7
		|=> instr_done && (instr_trap
		|| !float_carry_flag && !float_overflow_flag))
		else $error("compare flags wrong or late");
	AST_ZN_EXCL: assert property (!(float_zero_flag && float_negative_flag))
		else $error("zero and negative flags both set");
	AST_CARRY_CLR: assert property (instr_done && !instr_trap
		|-> !float_carry_flag)
		else $error("carry left set after instruction");
	AST_CODE_LEGAL: assert property (instr_trap
		|-> float_error_code inside {4'h4, 4'h8, 4'ha, 4'hc})
		else $error("trap with unknown error code");
	cover property (take && instr_word[15:8] == 8'hf9);
	cover property (instr_trap && float_error_code == 4'h8);
	cover property ($rose(busy) && issued_op == 8'hf3);
endmodule : fpdcm_unit_properties
bind fpdcm_unit fpdcm_unit_properties fpdcm_unit_properties_inst
(
	.mclk(mclk), .rst(rst), .instr_valid(instr_valid),
	.instr_word(instr_word), .float_source_operand(float_source_operand),
	.busy(busy), .instr_done(instr_done), .instr_trap(instr_trap),
	.float_error_code(float_error_code),
	.float_carry_flag(float_carry_flag),
	.float_overflow_flag(float_overflow_flag),
	.float_zero_flag(float_zero_flag),
	.float_negative_flag(float_negative_flag)
);
`default_nettype wire

// [fpdcm_host.sv]
// Host core model issuing floating instructions to the unit
`timescale 1ns/10ps
`default_nettype none
module fpdcm_host
(
	// Clock
	input  wire logic        mclk,
	// Issue side
	output logic             instr_valid,
	output logic      [15:0] instr_word,
	output logic      [63:0] float_source_operand,
	// Completion side
	input  wire logic        instr_done,
	input  wire logic        instr_trap
);
	initial
	begin
		instr_valid = 1'b0;
		instr_word = 16'h0000;
		float_source_operand = 64'h0;
	end
	// One issue, then a bounded wait; ok stays low on timeout
	task automatic issue(input logic [15:0] w, input logic [63:0] s,
		output logic trap, output logic ok);
		int i;
		ok = 1'b0;
		trap = 1'b0;
		@(posedge mclk);
		instr_valid <= 1'b1;
		instr_word <= w;
		float_source_operand <= s;
		@(posedge mclk);
		instr_valid <= 1'b0;
		// Unqualified operand must not look like the last one
		instr_word <= ~w;
		float_source_operand <= ~s;
		for (i = 0; i < 200 && !ok; i++)
		begin
			#1;
			if (instr_done === 1'b1)
			begin
				ok = 1'b1;
				trap = instr_trap;
			end
			else
				@(posedge mclk);
		end
	endtask : issue
endmodule : fpdcm_host
`default_nettype wire

// [fpdcm_unit_tb.sv]
// Self-checking bench of the divide, compare and integerize unit
`timescale 1ns/10ps
`default_nettype none
module fpdcm_unit_tb;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic        instr_valid;
	logic [15:0] instr_word;
	logic [63:0] float_source_operand;
	logic        busy;
	logic        instr_done;
	logic        instr_trap;
	logic [3:0]  float_error_code;
	logic        float_carry_flag;
	logic        float_overflow_flag;
	logic        float_zero_flag;
	logic        float_negative_flag;
	int          num_errors = 0;
	int          n_tests = 0;
	fpdcm_unit fpdcm_unit_inst
	(
		.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .instr_valid(instr_valid),
		.instr_word(instr_word),
		.float_source_operand(float_source_operand), .busy(busy),
		.instr_done(instr_done), .instr_trap(instr_trap),
		.float_error_code(float_error_code),
		.float_carry_flag(float_carry_flag),
		.float_overflow_flag(float_overflow_flag),
		.float_zero_flag(float_zero_flag),
		.float_negative_flag(float_negative_flag)
	);
	fpdcm_host fpdcm_host_inst
	(
		.mclk(mclk), .instr_valid(instr_valid), .instr_word(instr_word),
		.float_source_operand(float_source_operand),
		.instr_done(instr_done), .instr_trap(instr_trap)
	);
	always #50 mclk = ~mclk;
	task automatic chk(input logic [63:0] got, input logic [63:0] want);
		n_tests++;
		if (got !== want)
		begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask : chk
	task automatic final_report;
		$display("Checks %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd
	task automatic run(input logic [15:0] w, input logic [63:0] s,
		output logic t);
		logic ok;
		fpdcm_host_inst.issue(w, s, t, ok);
		chk({63'h0, ok}, 64'h1);
		if (ok !== 1'b1)
			final_report();
	endtask : run
	task automatic t_regs;
		logic [31:0] v;
		rd(4'h8, v);
		chk(v, 32'h0000_1000);
		rd(4'h9, v);
		chk(v, 32'h0);
		wr(4'hb, 32'hffff_ffff);
		rd(4'hb, v);
		chk(v, 32'h0);
		$display("Register test done");
	endtask : t_regs
	task automatic t_compare;
		logic t;
		logic [31:0] v;
		wr(4'h8, 32'h1000);
		wr(4'h0, 32'h4100_0000);
		run(16'hf700, 64'h4080_0000_0000_0000, t);
		chk({t, float_carry_flag, float_overflow_flag, float_zero_flag,
			float_negative_flag}, 5'b00001);
		rd(4'h0, v);
		chk(v, 32'h4100_0000);
		run(16'hf700, 64'h4100_0000_0000_0000, t);
		chk({t, float_zero_flag, float_negative_flag}, 3'b010);
		run(16'hf700, 64'h0055_0000_0000_0000, t);
		chk({t, float_zero_flag, float_negative_flag}, 3'b001);
		$display("Compare test done");
	endtask : t_compare
	// Status given as bits 12:5; code zero means no trap expected
	task automatic div_one(input logic [7:0] st, input logic [31:0] dst,
		input logic [31:0] src, input logic [31:0] want,
		input logic [3:0] code, input logic fv);
		logic t;
		logic [31:0] v;
		wr(4'h8, {19'h0, st, 5'h0});
		wr(4'h0, dst);
		run(16'hf900, {src, 32'h0}, t);
		chk(t, code != 4'h0);
		rd(4'h0, v);
		chk(v, want);
		if (code != 4'h0)
		begin
			rd(4'h9, v);
			chk(v, code);
		end
		else
			chk({float_overflow_flag, float_zero_flag, float_negative_flag},
				{fv, want[30:23] == 8'h00, want[31]});
		$display("Divide %h by %h done", dst, src);
	endtask : div_one
	task automatic mod_one(input logic [1:0] sel, input logic [31:0] dst,
		input logic [31:0] src, input logic [31:0] gfr,
		input logic [31:0] nint);
		logic t;
		logic [31:0] v;
		wr(4'h8, 32'h1000);
		wr({1'b0, sel, 1'b0}, dst);
		wr({1'b0, sel + 2'd1, 1'b0}, 32'h5a5a_0000);
		run({8'hf3, sel, 6'h00}, {src, 32'h0}, t);
		chk(t, 1'b0);
		chk({float_zero_flag, float_negative_flag},
			{gfr[30:23] == 8'h00, gfr[31]});
		rd({1'b0, sel, 1'b0}, v);
		chk(v, gfr);
		rd({1'b0, sel + 2'd1, 1'b0}, v);
		chk(v, nint);
		$display("Integerize on accumulator %0d done", sel);
	endtask : mod_one
	initial
	begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		t_regs();
		t_compare();
		div_one(8'h80, 32'h41400000, 32'h41000000, 32'h40c00000, 0, 0);
		div_one(8'h81, 32'h40800000, 32'h41400000, 32'h3faaaaaa, 0, 0);
		div_one(8'h80, 32'h40800000, 32'h41400000, 32'h3faaaaab, 0, 0);
		// Double rounding lands in the low word, high word stays chopped
		div_one(8'h84, 32'h40800000, 32'h41400000, 32'h3faaaaaa, 0, 0);
		div_one(8'h80, 32'h41400000, 32'h00400000, 32'h41400000, 4, 0);
		div_one(8'h80, 32'h00400000, 32'h41000000, 32'h00000000, 0, 0);
		div_one(8'h90, 32'h7f800000, 32'h00800000, 32'h3f800000, 8, 1);
		div_one(8'h80, 32'h7f800000, 32'h00800000, 32'h00000000, 0, 1);
		div_one(8'ha0, 32'h00800000, 32'h7f800000, 32'h41800000, 10, 0);
		div_one(8'h80, 32'h00800000, 32'h7f800000, 32'h00000000, 0, 0);
		div_one(8'h00, 32'h7f800000, 32'h00800000, 32'h3f800000, 0, 1);
		div_one(8'hc0, 32'h41000000, 32'h80000000, 32'h41000000, 12, 0);
		mod_one(0, 32'h40c00000, 32'h40c00000, 32'h3f800000, 32'h41000000);
		mod_one(1, 32'h40c00000, 32'h40c00000, 32'h3f800000, 32'h5a5a0000);
		mod_one(0, 32'hc0c00000, 32'h40c00000, 32'hbf800000, 32'hc1000000);
		mod_one(0, 32'h4c800000, 32'h40c00000, 32'h00000000, 32'h4cc00000);
		mod_one(0, 32'h7f800000, 32'h7f800000, 32'h00000000, 32'h00000000);
		mod_one(0, 32'h00800000, 32'h00800000, 32'h00000000, 32'h00000000);
		final_report();
	end
endmodule : fpdcm_unit_tb
`default_nettype wire
